// [include/ccfg_pkg.sv]
// Functional notes
// - Termination allowed only when enable bit set
// - Watchdog period off, 40, 80, 160 s
// - Timer enable gates precharge and fast timers
// - Fast timer 20 h or 10 h
// - Warm band limits voltage to 4.1 V
// - Overvoltage threshold selected by two bits
// - Boost voltage selected by two bits
// - Input limit 3.9 V plus 100 mV steps
// - Detection bit self-clears when detection completes
// - Safety timer half rate while limiting
// - Switch disable bit enters ship mode
// - Reset waits for adapter removal unless enabled
// - Switch-off immediate or after 10 s delay
// - System reset needs enable and disable bits
// - Input limit tracks battery plus offset
// - Watchdog expiry sets fault, default mode
package ccfg_pkg;
   localparam logic [7:0] ADDR_CTRL_ONE   = 8'h05;       // Control one
   localparam logic [7:0] ADDR_CTRL_TWO   = 8'h06;       // Control two
   localparam logic [7:0] ADDR_CTRL_THREE = 8'h07;       // Control three
   localparam logic [7:0] RST_CTRL_ONE    = 8'h9e;       // Control one reset
   localparam logic [7:0] RST_CTRL_TWO    = 8'he6;       // Control two reset
   localparam logic [7:0] RST_CTRL_THREE  = 8'h4c;       // Control three reset
   // Bits of control three restored by watchdog (7,6,2)
   localparam logic [7:0] WD_MASK_THREE   = 8'hc4;
   // Field positions
   localparam int BIT_TERM_EN   = 7;
   localparam int BIT_WD_HI     = 5;
   localparam int BIT_WD_LO     = 4;
   localparam int BIT_TMR_EN    = 3;
   localparam int BIT_FAST_LEN  = 2;
   localparam int BIT_THERM     = 1;
   localparam int BIT_WARM_V    = 0;
   localparam int BIT_OVP_LO    = 6;
   localparam int BIT_BOOST_LO  = 4;
   localparam int BIT_VLIM_LO   = 0;
   localparam int BIT_DETECT    = 7;
   localparam int BIT_SLOWDOWN  = 6;
   localparam int BIT_SW_DIS    = 5;
   localparam int BIT_RST_ADAPT = 4;
   localparam int BIT_SW_DLY    = 3;
   localparam int BIT_SYS_RST   = 2;
   localparam int BIT_TRACK_LO  = 0;
   // Timing at 10 MHz
   localparam longint CLK_HZ      = 10_000_000;
   localparam longint WD_UNIT_S   = 40;              // Base watchdog period in s
   localparam longint SW_DLY_S    = 10;              // Switch-off delay in s
   localparam longint PRE_H       = 2;               // Precharge length in h
   localparam longint FAST_LONG_H = 20;              // Fast charge, bit 0
   localparam longint FAST_SHRT_H = 10;              // Fast charge, bit 1
   localparam longint WD_UNIT_CYC = WD_UNIT_S * CLK_HZ;
   localparam longint SW_DLY_CYC  = SW_DLY_S * CLK_HZ;
   localparam longint PRE_CYC     = PRE_H * 3600 * CLK_HZ;
   localparam longint FAST_L_CYC  = FAST_LONG_H * 3600 * CLK_HZ;
   localparam longint FAST_S_CYC  = FAST_SHRT_H * 3600 * CLK_HZ;
   // Analog codes in mV
   localparam logic [15:0] VLIM_BASE_MV = 16'd3900;
   localparam logic [15:0] VLIM_STEP_MV = 16'd100;
   localparam logic [15:0] WARM_MV      = 16'd4100;

   // Charge phase
   typedef enum logic [2:0] {
      CCFG_IDLE = 3'b001,
      CCFG_PRE  = 3'b010,
      CCFG_FAST = 3'b100
   } ccfg_phase_t;

   // Whole module state
   typedef struct packed {
      logic [7:0]  ctrl_one;
      logic [7:0]  ctrl_two;
      logic [7:0]  ctrl_three;
      logic [7:0]  rdata;
      logic        wd_fault;
      logic [41:0] wd_cnt;
      logic [41:0] sw_cnt;
      logic        sw_off;
      logic        sys_rst;
      logic [47:0] sfty_cnt;
      logic        half_tick;
      logic        sfty_exp;
      ccfg_phase_t phase;
   } ccfg_state_t;
endpackage : ccfg_pkg

// [rtl/ccfg_regs.sv]
`timescale 1ns/100ps
module ccfg_regs
   import ccfg_pkg::*;
#(
   parameter longint WD_UNIT_CYCLES = WD_UNIT_CYC,   // 40 s in cycles
   parameter longint SW_DLY_CYCLES  = SW_DLY_CYC,    // 10 s in cycles
   parameter longint PRE_CYCLES     = PRE_CYC,       // 2 h in cycles
   parameter longint FAST_L_CYCLES  = FAST_L_CYC,    // 20 h in cycles
   parameter longint FAST_S_CYCLES  = FAST_S_CYC     // 10 h in cycles
) (
   input  wire logic        i_clk,
   input  wire logic        i_nrst,
   input  wire logic        i_wr,                    // Write strobe
   input  wire logic        i_rd,                    // Read strobe
   input  wire logic [7:0]  i_addr,                  // Register address
   input  wire logic [7:0]  i_wdata,                 // Write data
   input  wire logic        i_wd_kick,               // Host access resets watchdog
   input  wire logic        i_det_done,              // Detection finished
   input  wire logic        i_adapter,               // Adapter present
   input  wire logic        i_charging,              // Charger wants to charge
   input  wire logic        i_low_batt,              // Below precharge threshold
   input  wire logic        i_in_limit,              // Input V or I limiting
   input  wire logic        i_band_reduce,           // Cool/warm with reduced current
   input  wire logic        i_therm_reg,             // Thermal regulation
   input  wire logic [15:0] i_vbat_mv,               // Battery voltage
   input  wire logic [15:0] i_vreg_mv,               // Programmed charge voltage
   input  wire logic        i_warm,                  // Warm band
   output logic [7:0]       o_rdata,                 // Read data
   output logic             o_term_en,               // Termination allowed
   output logic             o_therm_sel,             // Thermal threshold select
   output logic [1:0]       o_ovp_sel,               // Overvoltage threshold code
   output logic [1:0]       o_boost_sel,             // Boost voltage code
   output logic [15:0]      o_vlim_mv,               // Effective input limit
   output logic [15:0]      o_vchg_mv,               // Charge voltage limit
   output logic             o_detect,                // Detection request
   output logic             o_wd_fault,              // Watchdog fault, default mode
   output logic             o_sw_off,                // Battery switch off
   output logic             o_sys_rst,               // Full system reset
   output logic             o_sfty_exp               // Safety timer expired
);

   ccfg_state_t s_reg;                               // Registered state
   ccfg_state_t s_next;                              // Next state

   // Watchdog limit from two-bit code; zero means off
   function automatic logic [41:0] wd_limit(input logic [1:0] code);
      logic [41:0] r;
      r = 42'h0;
      unique case (code)
         2'b01:   r = 42'(WD_UNIT_CYCLES);
         2'b10:   r = 42'(2 * WD_UNIT_CYCLES);
         2'b11:   r = 42'(4 * WD_UNIT_CYCLES);
         default: r = 42'h0;
      endcase
      return r;
   endfunction : wd_limit

   // Tracking offset in mV
   function automatic logic [15:0] track_mv(input logic [1:0] code);
      logic [15:0] r;
      r = 16'h0;
      unique case (code)
         2'b01:   r = 16'd200;
         2'b10:   r = 16'd250;
         2'b11:   r = 16'd300;
         default: r = 16'h0;
      endcase
      return r;
   endfunction : track_mv

   logic [15:0] reg_vlim;                            // Register limit
   logic [15:0] trk_vlim;                            // Battery-tracked limit
   logic        slow;                                // Half-rate condition
   logic [47:0] sfty_lim;                            // Current phase limit

   // Next state
   always_comb begin
      s_next = s_reg;
      // Writes from host
      if (i_wr) begin
         unique case (i_addr)
            ADDR_CTRL_ONE:   s_next.ctrl_one   = i_wdata;
            ADDR_CTRL_TWO:   s_next.ctrl_two   = i_wdata;
            ADDR_CTRL_THREE: s_next.ctrl_three = i_wdata;
            default: ;                               // Unmapped ignored
         endcase
      end
      // Detection done clears, but a new write of 1 wins
      if (i_det_done && !(i_wr && i_addr == ADDR_CTRL_THREE && i_wdata[BIT_DETECT]))
         s_next.ctrl_three[BIT_DETECT] = 1'b0;
      // Read data registered
      if (i_rd) begin
         unique case (i_addr)
            ADDR_CTRL_ONE:   s_next.rdata = s_reg.ctrl_one;
            ADDR_CTRL_TWO:   s_next.rdata = s_reg.ctrl_two;
            ADDR_CTRL_THREE: s_next.rdata = s_reg.ctrl_three;
            default:         s_next.rdata = 8'h00;
         endcase
      end
      // Watchdog: any host access restarts, and host mode resumes
      if (i_wd_kick || i_wr || i_rd) begin
         s_next.wd_cnt   = 42'h0;
         s_next.wd_fault = 1'b0;
      end else if (wd_limit(s_reg.ctrl_one[BIT_WD_HI:BIT_WD_LO]) == 42'h0) begin
         s_next.wd_cnt = 42'h0;
      end else if (s_reg.wd_cnt + 42'h1 >= wd_limit(s_reg.ctrl_one[BIT_WD_HI:BIT_WD_LO])) begin
         // Expiry: default mode, all of control one and masked control three bits restored
         s_next.wd_cnt     = 42'h0;
         s_next.wd_fault   = 1'b1;
         s_next.ctrl_one   = RST_CTRL_ONE;
         s_next.ctrl_three = (s_reg.ctrl_three & ~WD_MASK_THREE)
                           | (RST_CTRL_THREE & WD_MASK_THREE);
      end else begin
         s_next.wd_cnt = s_reg.wd_cnt + 42'h1;
      end
      // Battery switch: delay counts from disable set
      if (!s_reg.ctrl_three[BIT_SW_DIS]) begin
         s_next.sw_cnt = 42'h0;
         s_next.sw_off = 1'b0;
      end else if (!s_reg.ctrl_three[BIT_SW_DLY]) begin
         s_next.sw_off = 1'b1;
      end else if (s_reg.sw_cnt + 42'h1 >= 42'(SW_DLY_CYCLES)) begin
         s_next.sw_off = 1'b1;
      end else begin
         s_next.sw_cnt = s_reg.sw_cnt + 42'h1;
      end
      // Full reset needs enable, switch off, and adapter condition
      s_next.sys_rst = s_reg.ctrl_three[BIT_SYS_RST] && s_reg.sw_off
                     && (s_reg.ctrl_three[BIT_RST_ADAPT] || !i_adapter);
      // Safety timer phases
      s_next.half_tick = ~s_reg.half_tick;
      if (!s_reg.ctrl_one[BIT_TMR_EN] || !i_charging) begin
         s_next.phase    = CCFG_IDLE;
         s_next.sfty_cnt = 48'h0;
         s_next.sfty_exp = 1'b0;
      end else begin
         unique case (s_reg.phase)
            CCFG_IDLE: begin
               s_next.phase    = i_low_batt ? CCFG_PRE : CCFG_FAST;
               s_next.sfty_cnt = 48'h0;
            end
            CCFG_PRE: begin
               if (!i_low_batt) begin
                  s_next.phase    = CCFG_FAST;
                  s_next.sfty_cnt = 48'h0;
               end
            end
            CCFG_FAST: ;
         endcase
         // Count at half rate while slowed
         if (s_reg.phase != CCFG_IDLE && !s_reg.sfty_exp && (!slow || s_reg.half_tick)) begin
            if (s_reg.sfty_cnt + 48'h1 >= sfty_lim)
               s_next.sfty_exp = 1'b1;
            else
               s_next.sfty_cnt = s_reg.sfty_cnt + 48'h1;
         end
      end
   end

   // Slow-down condition and phase limit
   always_comb begin
      slow = s_reg.ctrl_three[BIT_SLOWDOWN]
           && (i_in_limit || i_band_reduce || i_therm_reg);
      if (s_reg.phase == CCFG_PRE)
         sfty_lim = 48'(PRE_CYCLES);
      else if (s_reg.ctrl_one[BIT_FAST_LEN])
         sfty_lim = 48'(FAST_S_CYCLES);
      else
         sfty_lim = 48'(FAST_L_CYCLES);
   end

   // Effective input limit: higher of register and tracked
   always_comb begin
      reg_vlim = VLIM_BASE_MV
               + VLIM_STEP_MV * {12'h0, s_reg.ctrl_two[BIT_VLIM_LO +: 4]};
      trk_vlim = (s_reg.ctrl_three[BIT_TRACK_LO +: 2] == 2'b00) ? 16'h0
               : i_vbat_mv + track_mv(s_reg.ctrl_three[BIT_TRACK_LO +: 2]);
      o_vlim_mv = (trk_vlim > reg_vlim) ? trk_vlim : reg_vlim;
   end

   // Warm band voltage cap
   always_comb begin
      if (i_warm && !s_reg.ctrl_one[BIT_WARM_V] && i_vreg_mv > WARM_MV)
         o_vchg_mv = WARM_MV;
      else
         o_vchg_mv = i_vreg_mv;
   end

   // State register
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         s_reg            <= '0;
         s_reg.ctrl_one   <= RST_CTRL_ONE;
         s_reg.ctrl_two   <= RST_CTRL_TWO;
         s_reg.ctrl_three <= RST_CTRL_THREE;
         s_reg.wd_fault   <= 1'b1;                   // Default mode after reset
         s_reg.phase      <= CCFG_IDLE;
      end else begin
         s_reg <= s_next;
      end
   end

   // Outputs from flops; detect also gated by adapter input
   assign o_rdata     = s_reg.rdata;
   assign o_term_en   = s_reg.ctrl_one[BIT_TERM_EN];
   assign o_therm_sel = s_reg.ctrl_one[BIT_THERM];
   assign o_ovp_sel   = s_reg.ctrl_two[BIT_OVP_LO +: 2];
   assign o_boost_sel = s_reg.ctrl_two[BIT_BOOST_LO +: 2];
   assign o_detect    = s_reg.ctrl_three[BIT_DETECT] && i_adapter;
   assign o_wd_fault  = s_reg.wd_fault;
   assign o_sw_off    = s_reg.sw_off;
   assign o_sys_rst   = s_reg.sys_rst;
   assign o_sfty_exp  = s_reg.sfty_exp;

endmodule : ccfg_regs

// [verification/ccfg_regs_sva.sv]
`timescale 1ns/100ps
module ccfg_regs_sva
   import ccfg_pkg::*;
(
   input wire logic        i_clk,
   input wire logic        i_nrst,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [7:0]  i_addr,
   input wire logic [7:0]  i_wdata,
   input wire logic        i_det_done,
   input wire logic        i_adapter,
   input wire logic        i_warm,
   input wire logic [15:0] i_vreg_mv,
   input wire logic        o_term_en,
   input wire logic [1:0]  o_ovp_sel,
   input wire logic [1:0]  o_boost_sel,
   input wire logic [15:0] o_vlim_mv,
   input wire logic [15:0] o_vchg_mv,
   input wire logic        o_detect,
   input wire logic        o_wd_fault,
   input wire logic        o_sw_off,
   input wire logic        o_sys_rst
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   // Write decodes, one per register
   wire wr1 = i_wr && (i_addr == ADDR_CTRL_ONE);
   wire wr2 = i_wr && (i_addr == ADDR_CTRL_TWO);
   wire wr3 = i_wr && (i_addr == ADDR_CTRL_THREE);
   property p_term; wr1 |=> o_term_en == $past(i_wdata[7]); endproperty
   a_term: assert property (p_term) else $error("term enable not written");
   property p_sel; wr2 |=> {o_ovp_sel, o_boost_sel} == $past(i_wdata[7:4]); endproperty
   a_sel: assert property (p_sel) else $error("threshold codes not written");
   // Tracking may only raise the limit, never lower it
   property p_vlim; wr2 |=> o_vlim_mv >= VLIM_BASE_MV + VLIM_STEP_MV * $past(i_wdata[3:0]); endproperty
   a_vlim: assert property (p_vlim) else $error("input limit too low");
   property p_vchg; (!i_warm || i_vreg_mv <= WARM_MV) |-> o_vchg_mv == i_vreg_mv; endproperty
   a_vchg: assert property (p_vchg) else $error("charge voltage clamped");
   property p_det; o_detect |-> i_adapter; endproperty
   a_det: assert property (p_det) else $error("detection without adapter");
   property p_det_clr; i_det_done && !wr3 |=> !o_detect; endproperty
   a_det_clr: assert property (p_det_clr) else $error("detect bit not cleared");
   property p_sw_now; wr3 && i_wdata[5] && !i_wdata[3] |-> ##2 o_sw_off; endproperty
   a_sw_now: assert property (p_sw_now) else $error("switch not off at once");
   property p_sw_dly; wr3 && i_wdata[5] && i_wdata[3] && !o_sw_off |=> (!o_sw_off) [*8]; endproperty
   a_sw_dly: assert property (p_sw_dly) else $error("switch off too early");
   property p_wd; (i_wr || i_rd) |=> !o_wd_fault; endproperty
   a_wd: assert property (p_wd) else $error("fault kept after access");
   // Main scenarios reached
   c_sw: cover property ($rose(o_sw_off));
   c_rst: cover property ($rose(o_sys_rst));
   c_wd: cover property ($rose(o_wd_fault));
endmodule : ccfg_regs_sva
bind ccfg_regs ccfg_regs_sva u_sva (.i_clk, .i_nrst, .i_wr, .i_rd, .i_addr, .i_wdata, .i_det_done,
   .i_adapter, .i_warm, .i_vreg_mv, .o_term_en, .o_ovp_sel, .o_boost_sel, .o_vlim_mv,
   .o_vchg_mv, .o_detect, .o_wd_fault, .o_sw_off, .o_sys_rst);

// [verification/ccfg_host.sv]
`timescale 1ns/100ps
module ccfg_host
   import ccfg_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic [7:0] i_rdata,
   output logic            o_wr,
   output logic            o_rd,
   output logic [7:0]      o_addr,
   output logic [7:0]      o_wdata
);
   // Bus idle at time zero
   initial begin
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = 8'h00;
      o_wdata = 8'h00;
   end
   // One byte per strobe; lines scrambled once released
   task automatic acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
      @(posedge i_clk);
      o_wr <= w;
      o_rd <= !w;
      o_addr <= a;
      o_wdata <= d;
      @(posedge i_clk);
      o_wr <= 1'b0;
      o_rd <= 1'b0;
      o_addr <= ~a;
      o_wdata <= ~d;
      #1;
      q = i_rdata;
   endtask : acc
   // Adapter reset armed before the switch opens
   task automatic ship(input logic [7:0] base);
      logic [7:0] q;
      acc(1'b1, ADDR_CTRL_THREE, base | 8'h10, q);
      acc(1'b1, ADDR_CTRL_THREE, base | 8'h30, q);
   endtask : ship
endmodule : ccfg_host

// [verification/ccfg_regs_tb.sv]
`timescale 1ns/100ps
module ccfg_regs_tb;
   import ccfg_pkg::*;
   logic        i_clk, i_nrst, i_wr, i_rd, i_wd_kick, i_det_done, i_adapter, i_charging;
   logic        i_low_batt, i_in_limit, i_band_reduce, i_therm_reg, i_warm;
   logic [7:0]  i_addr, i_wdata, o_rdata;
   logic [15:0] i_vbat_mv, i_vreg_mv, o_vlim_mv, o_vchg_mv;
   logic        o_term_en, o_therm_sel, o_detect, o_wd_fault, o_sw_off, o_sys_rst, o_sfty_exp;
   logic [1:0]  o_ovp_sel, o_boost_sel;
   logic [15:0] trk [4] = '{16'h0f3c, 16'h11f8, 16'h122a, 16'h125c}; // Tracked limits
   int          n_mismatch = 0;
   int          n_checks = 0;
   // Short counts keep the run brief
   ccfg_regs #(.WD_UNIT_CYCLES(100), .SW_DLY_CYCLES(20), .PRE_CYCLES(50), .FAST_L_CYCLES(80),
      .FAST_S_CYCLES(40)) DUT (.i_clk, .i_nrst, .i_wr, .i_rd, .i_addr, .i_wdata, .i_wd_kick,
      .i_det_done, .i_adapter, .i_charging, .i_low_batt, .i_in_limit, .i_band_reduce,
      .i_therm_reg, .i_vbat_mv, .i_vreg_mv, .i_warm, .o_rdata, .o_term_en, .o_therm_sel,
      .o_ovp_sel, .o_boost_sel, .o_vlim_mv, .o_vchg_mv, .o_detect, .o_wd_fault, .o_sw_off,
      .o_sys_rst, .o_sfty_exp);
   ccfg_host h (.i_clk, .i_rdata(o_rdata), .o_wr(i_wr), .o_rd(i_rd), .o_addr(i_addr),
      .o_wdata(i_wdata));
   task automatic chk(input logic [15:0] got, exp, input string m);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   task automatic rchk(input logic [7:0] a, e);
      logic [7:0] q;
      h.acc(1'b0, a, 8'h00, q);
      chk({8'h00, q}, {8'h00, e}, "read back");
   endtask : rchk
   task automatic wr(input logic [7:0] a, d);
      logic [7:0] q;
      h.acc(1'b1, a, d, q);
   endtask : wr
   // Settle just past the edge
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask : cyc
   task automatic finish_test;
      $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : finish_test
   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end
   // Hang guard, nearly six times the expected run
   initial begin
      #1_000_000;
      n_mismatch++;
      finish_test();
   end
   initial begin
      {i_wd_kick, i_det_done, i_adapter, i_charging, i_low_batt} = 5'h00;
      {i_in_limit, i_band_reduce, i_therm_reg, i_warm, i_nrst} = 5'h00;
      i_vbat_mv = 16'h1130;
      i_vreg_mv = 16'h1068;
      repeat (20) @(posedge i_clk);
      i_nrst <= 1'b1;
      cyc(1);
      chk(o_wd_fault, 1'b1, "default mode");
      rchk(ADDR_CTRL_ONE, 8'h9e);
      rchk(ADDR_CTRL_TWO, 8'he6);
      rchk(ADDR_CTRL_THREE, 8'h4c);
      rchk(8'h08, 8'h00);
      $display("Test reset values done");
      @(posedge i_clk) i_warm <= 1'b1;
      wr(ADDR_CTRL_ONE, 8'h61);
      rchk(ADDR_CTRL_ONE, 8'h61);
      chk(o_term_en, 1'b0, "term off");
      chk(o_vchg_mv, 16'h1068, "warm uses vreg");
      wr(ADDR_CTRL_ONE, 8'h9e);
      chk(o_term_en, 1'b1, "term on");
      chk(o_vchg_mv, 16'h1004, "warm clamp");
      $display("Test control one done");
      for (int c = 0; c < 4; c++) begin
         wr(ADDR_CTRL_TWO, {4{c[1:0]}});
         chk(o_ovp_sel, c[1:0], "ovp code");
         chk(o_boost_sel, c[1:0], "boost code");
         chk(o_vlim_mv, 16'(16'h0f3c + 16'h01f4 * c), "input limit");
      end
      wr(ADDR_CTRL_TWO, 8'he0);
      for (int t = 0; t < 4; t++) begin
         wr(ADDR_CTRL_THREE, 8'h4c | 8'(t));
         chk(o_vlim_mv, trk[t], "tracking");
      end
      $display("Test thresholds done");
      @(posedge i_clk) i_adapter <= 1'b1;
      wr(ADDR_CTRL_THREE, 8'hcc);
      chk(o_detect, 1'b1, "detect start");
      @(posedge i_clk) i_det_done <= 1'b1;
      @(posedge i_clk) i_det_done <= 1'b0;
      cyc(1);
      chk(o_detect, 1'b0, "detect end");
      rchk(ADDR_CTRL_THREE, 8'h4c);
      wr(ADDR_CTRL_THREE, 8'h24);
      cyc(3);
      chk(o_sw_off, 1'b1, "ship mode");
      chk(o_sys_rst, 1'b0, "waits for removal");
      @(posedge i_clk) i_adapter <= 1'b0;
      cyc(4);
      chk(o_sys_rst, 1'b1, "reset after removal");
      wr(ADDR_CTRL_THREE, 8'h20);
      cyc(3);
      chk(o_sys_rst, 1'b0, "reset disabled");
      wr(ADDR_CTRL_THREE, 8'h4c);
      cyc(3);
      chk(o_sw_off, 1'b0, "switch on");
      @(posedge i_clk) i_adapter <= 1'b1;
      h.ship(8'h0c);
      cyc(10);
      chk(o_sw_off, 1'b0, "delay running");
      cyc(15);
      chk(o_sw_off, 1'b1, "delay over");
      chk(o_sys_rst, 1'b1, "reset with adapter");
      @(posedge i_clk) i_adapter <= 1'b0;
      $display("Test battery switch done");
      wr(ADDR_CTRL_THREE, 8'h09);
      for (int k = 0; k < 3; k++) begin
         wr(ADDR_CTRL_ONE, 8'h1e + 8'(k) * 8'h10);
         cyc(90 << k);
         chk(o_wd_fault, 1'b0, "watchdog early");
         cyc(20 << k);
         chk(o_wd_fault, 1'b1, "watchdog expired");
      end
      chk(o_term_en, 1'b1, "term restored");
      rchk(ADDR_CTRL_THREE, 8'h4d);
      rchk(ADDR_CTRL_ONE, 8'h9e);
      // Kick pulse alone must restart the 40 s count
      cyc(80);
      @(posedge i_clk) i_wd_kick <= 1'b1;
      @(posedge i_clk) i_wd_kick <= 1'b0;
      cyc(80);
      chk(o_wd_fault, 1'b0, "kick restarts watchdog");
      wr(ADDR_CTRL_ONE, 8'h0e);
      cyc(500);
      chk(o_wd_fault, 1'b0, "watchdog off");
      $display("Test watchdog done");
      @(posedge i_clk) i_charging <= 1'b1;
      cyc(32);
      chk(o_sfty_exp, 1'b0, "fast timer early");
      cyc(16);
      chk(o_sfty_exp, 1'b1, "fast timer 10 h");
      @(posedge i_clk) i_nrst <= 1'b0;
      @(posedge i_clk) i_nrst <= 1'b1;
      i_in_limit <= 1'b1;
      cyc(64);
      chk(o_sfty_exp, 1'b0, "half rate early");
      cyc(32);
      chk(o_sfty_exp, 1'b1, "half rate expired");
      $display("Test safety timer done");
      finish_test();
   end
endmodule : ccfg_regs_tb
